// *** src/ngh_pkg.sv ***
// Package: constants, types and register map of the guarding and heartbeat supervisor
//
// Contract
// - Lifetime is guard time times factor; expiry flags.
// - Zero guard time or factor disables lifetime check.
// - Guard reply uses 700h plus node id, length one.
// - State codes 00h, 04h, 05h, 7Fh in seven bits.
// - Guard reply bit 7 starts zero, toggles each reply.
// - Heartbeat sent every producer period; zero disables it.
// - Heartbeat carries one state byte; no master needed.
// - Heartbeat state bit 7 always zero.
// - Five consumer entries, each id plus timeout.
// - Consumer monitoring starts after first heartbeat.
// - Consumer timeout without heartbeat raises error event.
// - Zero consumer timeout disables that entry.
// - Entry: bits 31-24 zero, id 23-16, time 15-0.
// - Heartbeat and guarding stay active when stopped.
package ngh_pkg;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [15:0] NGH_IDX_GUARD = 16'h100C;
    localparam logic [15:0] NGH_IDX_LIFE = 16'h100D;
    localparam logic [15:0] NGH_IDX_CONS = 16'h1016;
    localparam logic [15:0] NGH_IDX_PROD = 16'h1017;
    localparam logic [15:0] NGH_IDX_IRQ_STAT = 16'h1F00;
    localparam logic [15:0] NGH_IDX_IRQ_MASK = 16'h1F01;
    localparam logic [15:0] NGH_IDX_CTRL = 16'h1F02;
    localparam logic [15:0] NGH_IDX_STATUS = 16'h1F03;
    localparam int NGH_ADDR_W = 18;
    localparam int NGH_CONS_N = 5;

    // ----------------------------------------
    // Consumer entry field layout
    // ----------------------------------------
    localparam int NGH_CONS_ID_LSB = 16;
    localparam int NGH_CONS_TIME_LSB = 0;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] NGH_RST_GUARD = 16'h0000;
    localparam logic [7:0] NGH_RST_LIFE = 8'h00;
    localparam logic [31:0] NGH_RST_CONS = 32'h0000_0000;
    localparam logic [15:0] NGH_RST_PROD = 16'h0000;

    // ----------------------------------------
    // Frame and state constants
    // ----------------------------------------
    localparam logic [10:0] NGH_COB_BASE = 11'h700;
    localparam logic [3:0] NGH_DLC = 4'h1;
    localparam logic [6:0] NGH_ST_BOOT = 7'h00;
    localparam logic [6:0] NGH_ST_STOP = 7'h04;
    localparam logic [6:0] NGH_ST_OPER = 7'h05;
    localparam logic [6:0] NGH_ST_PREOP = 7'h7F;

    // ----------------------------------------
    // Status bit positions (interrupt events)
    // ----------------------------------------
    localparam int NGH_EV_LIFE = 0;
    localparam int NGH_EV_CONS_LSB = 1;
    localparam int NGH_EV_W = 6;

    // ----------------------------------------
    // Timing: one millisecond at 125 MHz
    // ----------------------------------------
    localparam int NGH_CLK_MHZ = 125;
    localparam int NGH_TICK_US = 1000;
    localparam int NGH_TICK_CYC = NGH_TICK_US * NGH_CLK_MHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        NGH_NMT_BOOT,
        NGH_NMT_PREOP,
        NGH_NMT_OPER,
        NGH_NMT_STOP
    } ngh_nmt_e;

    // Outgoing frame towards the CAN controller
    typedef struct packed {
        logic [10:0] cob_id;
        logic [3:0] dlc;
        logic [7:0] data0;
    } ngh_frame_s;

endpackage

// *** src/ngh_cons_entry.sv ***
// One heartbeat consumer entry: arming and timeout supervision
`timescale 1ns/1ps
module ngh_cons_entry #(
    parameter int TW = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Configuration
    input wire logic [7:0] node_id,
    input wire logic [TW-1:0] timeout,
    // Events
    input wire logic ms_tick,
    input wire logic hb_seen,
    input wire logic [7:0] hb_node,
    // Result
    output logic armed,
    output logic expired
);

    // ----------------------------------------
    // Local state
    // ----------------------------------------
    logic [TW-1:0] remain; // Milliseconds left
    logic [TW-1:0] prev_timeout; // Detects reconfiguration
    wire disabled = (timeout == '0);
    wire match = hb_seen && (hb_node == node_id);
    wire reconf = (timeout != prev_timeout);
    wire hit_zero = armed && ms_tick && (remain == TW'(1));

    // Arm, reload and count down
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
            remain <= '0;
            expired <= 1'b0;
            prev_timeout <= '0;
        end else begin
            prev_timeout <= timeout;
            expired <= 1'b0;
            if (disabled || reconf) begin
                armed <= 1'b0;
            end else if (match) begin
                armed <= 1'b1;
                remain <= timeout;
            end else if (hit_zero) begin
                armed <= 1'b0;
                expired <= 1'b1;
            end else if (armed && ms_tick) begin
                remain <= remain - TW'(1);
            end
        end
    end

endmodule

// *** src/ngh_supervisor.sv ***
// Node guarding, life guarding and heartbeat producer and consumer supervisor
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module ngh_supervisor #(
    parameter int TICK_CYC = ngh_pkg::NGH_TICK_CYC,
    parameter int CONS_N = ngh_pkg::NGH_CONS_N
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [ngh_pkg::NGH_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Node identity and state from the NMT logic
    input wire logic [6:0] node_id,
    input wire ngh_pkg::ngh_nmt_e nmt_state,
    // Received frames from the CAN controller
    input wire logic rx_guard_rtr,
    input wire logic rx_hb_valid,
    input wire logic [7:0] rx_hb_node,
    // Transmit request to the CAN controller
    output ngh_pkg::ngh_frame_s tx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    // Events
    output logic life_error,
    output logic hb_error,
    output logic irq
);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [15:0] guard_period; // Poll period, ms
    logic [7:0] lifetime_multiplier; // Lifetime factor
    logic [15:0] producer_period; // Heartbeat period, ms
    logic [31:0] consumer_timeouts [CONS_N]; // Consumer entries
    logic [ngh_pkg::NGH_EV_W-1:0] irq_status; // Sticky events
    logic [ngh_pkg::NGH_EV_W-1:0] irq_mask; // Event enables
    logic [2:0] cons_sel; // Entry selected via control
    logic toggle_bit; // Guard reply toggle

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire [15:0] idx = reg_addr[ngh_pkg::NGH_ADDR_W-1:2];
    wire word_ok = (reg_addr[1:0] == 2'b00);
    wire sel_guard = word_ok && (idx == ngh_pkg::NGH_IDX_GUARD);
    wire sel_life = word_ok && (idx == ngh_pkg::NGH_IDX_LIFE);
    wire sel_cons = word_ok && (idx == ngh_pkg::NGH_IDX_CONS);
    wire sel_prod = word_ok && (idx == ngh_pkg::NGH_IDX_PROD);
    wire sel_stat = word_ok && (idx == ngh_pkg::NGH_IDX_IRQ_STAT);
    wire sel_mask = word_ok && (idx == ngh_pkg::NGH_IDX_IRQ_MASK);
    wire sel_ctrl = word_ok && (idx == ngh_pkg::NGH_IDX_CTRL);
    wire sel_status = word_ok && (idx == ngh_pkg::NGH_IDX_STATUS);
    wire cons_sel_ok = (cons_sel < 3'(CONS_N));
    wire [2:0] cons_idx = cons_sel_ok ? cons_sel : 3'h0;

    // ----------------------------------------
    // Millisecond tick
    // ----------------------------------------
    logic [$clog2(TICK_CYC)-1:0] tick_cnt; // Prescaler
    logic ms_tick; // One-cycle tick

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (tick_cnt == $bits(tick_cnt)'(TICK_CYC - 1));
            if (tick_cnt == $bits(tick_cnt)'(TICK_CYC - 1)) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    // Configuration storage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            guard_period <= ngh_pkg::NGH_RST_GUARD;
            lifetime_multiplier <= ngh_pkg::NGH_RST_LIFE;
            producer_period <= ngh_pkg::NGH_RST_PROD;
            irq_mask <= '0;
            cons_sel <= 3'h0;
            for (int i = 0; i < CONS_N; i++) begin
                consumer_timeouts[i] <= ngh_pkg::NGH_RST_CONS;
            end
        end else if (reg_wr) begin
            if (sel_guard) begin
                guard_period <= reg_wdata[15:0];
            end
            if (sel_life) begin
                lifetime_multiplier <= reg_wdata[7:0];
            end
            if (sel_prod) begin
                producer_period <= reg_wdata[15:0];
            end
            if (sel_mask) begin
                irq_mask <= reg_wdata[ngh_pkg::NGH_EV_W-1:0];
            end
            if (sel_ctrl) begin
                cons_sel <= reg_wdata[2:0];
            end
            if (sel_cons && cons_sel_ok) begin
                consumer_timeouts[cons_idx] <= {8'h00, reg_wdata[23:0]};
            end
        end
    end

    // ----------------------------------------
    // Life guarding
    // ----------------------------------------
    logic [23:0] life_remain; // Lifetime left, ms
    logic life_armed; // Monitoring after first poll
    wire [23:0] lifetime = guard_period * lifetime_multiplier;
    wire life_off = (guard_period == 16'h0000) || (lifetime_multiplier == 8'h00);
    wire life_expire = life_armed && ms_tick && (life_remain == 24'h1);

    // Lifetime countdown
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            life_remain <= '0;
            life_armed <= 1'b0;
        end else if (life_off) begin
            life_armed <= 1'b0;
        end else if (rx_guard_rtr) begin
            life_armed <= 1'b1;
            life_remain <= lifetime;
        end else if (life_expire) begin
            life_armed <= 1'b0;
        end else if (life_armed && ms_tick) begin
            life_remain <= life_remain - 24'h1;
        end
    end

    // ----------------------------------------
    // Heartbeat consumers
    // ----------------------------------------
    logic [CONS_N-1:0] cons_armed; // Entry monitoring
    logic [CONS_N-1:0] cons_expired; // Entry timed out

    for (genvar g = 0; g < CONS_N; g++) begin : g_cons
        ngh_cons_entry #(
            .TW(16)
        ) u_entry (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .node_id(consumer_timeouts[g][23:16]),
            .timeout(consumer_timeouts[g][15:0]),
            .ms_tick(ms_tick),
            .hb_seen(rx_hb_valid),
            .hb_node(rx_hb_node),
            .armed(cons_armed[g]),
            .expired(cons_expired[g])
        );
    end

    // ----------------------------------------
    // Heartbeat producer timer
    // ----------------------------------------
    logic [15:0] prod_cnt; // Ms since last heartbeat
    logic hb_due; // Heartbeat pending
    logic guard_due; // Guard reply pending
    logic sending_guard; // Frame in flight is a guard reply
    logic ngh_txq_hold; // Send blocked one cycle
    wire prod_on = (producer_period != 16'h0000);
    wire prod_fire = prod_on && ms_tick && (prod_cnt >= producer_period - 16'h1);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prod_cnt <= '0;
        end else if (!prod_on || prod_fire) begin
            prod_cnt <= '0;
        end else if (ms_tick) begin
            prod_cnt <= prod_cnt + 16'h1;
        end
    end

    // ----------------------------------------
    // State byte encoding
    // ----------------------------------------
    logic [6:0] state_code; // Seven-bit state
    always_comb begin
        case (nmt_state)
            ngh_pkg::NGH_NMT_BOOT: state_code = ngh_pkg::NGH_ST_BOOT;
            ngh_pkg::NGH_NMT_PREOP: state_code = ngh_pkg::NGH_ST_PREOP;
            ngh_pkg::NGH_NMT_OPER: state_code = ngh_pkg::NGH_ST_OPER;
            ngh_pkg::NGH_NMT_STOP: state_code = ngh_pkg::NGH_ST_STOP;
            default: state_code = ngh_pkg::NGH_ST_PREOP;
        endcase
    end

    // replies allowed in all running states
    wire may_send = (nmt_state != ngh_pkg::NGH_NMT_BOOT);
    wire [10:0] cob = ngh_pkg::NGH_COB_BASE + {4'h0, node_id};
    wire tx_done = tx_valid && tx_ready;
    wire pick_guard = guard_due && !hb_due;

    // ----------------------------------------
    // Transmit sequencing
    // ----------------------------------------
    // Pending flags, set wins over clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hb_due <= 1'b0;
            guard_due <= 1'b0;
        end else begin
            hb_due <= (prod_fire && may_send) || (hb_due && !(tx_done && !tx_frame.data0[7]
                && !sending_guard));
            guard_due <= (rx_guard_rtr && may_send) || (guard_due && !(tx_done && sending_guard));
        end
    end

    // Frame output register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
            sending_guard <= 1'b0;
            toggle_bit <= 1'b0;
        end else if (tx_done) begin
            tx_valid <= 1'b0;
            if (sending_guard) begin
                toggle_bit <= !toggle_bit;
            end
        end else if (!tx_valid && (hb_due || guard_due) && !ngh_txq_hold) begin
            tx_valid <= 1'b1;
            sending_guard <= pick_guard;
            tx_frame.cob_id <= cob;
            tx_frame.dlc <= ngh_pkg::NGH_DLC;
            tx_frame.data0 <= {pick_guard ? toggle_bit : 1'b0, state_code};
        end
    end

    // Hold one cycle after a send so pending flags settle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ngh_txq_hold <= 1'b0;
        end else begin
            ngh_txq_hold <= tx_done;
        end
    end

    // ----------------------------------------
    // Events and interrupt
    // ----------------------------------------
    wire [ngh_pkg::NGH_EV_W-1:0] ev_set = {cons_expired, life_expire};
    wire stat_clr_wr = reg_wr && sel_stat;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_status <= '0;
            life_error <= 1'b0;
            hb_error <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_status <= ev_set | (irq_status & ~(stat_clr_wr ?
                reg_wdata[ngh_pkg::NGH_EV_W-1:0] : '0));
            life_error <= life_expire;
            hb_error <= |cons_expired;
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    wire [31:0] status_word = {20'h0, toggle_bit, life_armed, 5'(cons_armed), 5'h0};
    wire [31:0] rd_mux = sel_guard ? {16'h0, guard_period} :
        sel_life ? {24'h0, lifetime_multiplier} :
        sel_cons ? (cons_sel_ok ? consumer_timeouts[cons_idx] : 32'h0) :
        sel_prod ? {16'h0, producer_period} :
        sel_stat ? {26'h0, irq_status} :
        sel_mask ? {26'h0, irq_mask} :
        sel_ctrl ? {29'h0, cons_sel} :
        sel_status ? status_word : 32'h0;

    // Read data one cycle later
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

endmodule

// *** testbench/ngh_supervisor_checker.sv ***
// Port-level assertions for the guarding and heartbeat supervisor
`timescale 1ns/1ps
module ngh_checker #(
    parameter int TICK_CYC = 125000,
    parameter int CONS_N = 5
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [ngh_pkg::NGH_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Identity and state
    input wire logic [6:0] node_id,
    input wire ngh_pkg::ngh_nmt_e nmt_state,
    // Receive side
    input wire logic rx_guard_rtr,
    input wire logic rx_hb_valid,
    input wire logic [7:0] rx_hb_node,
    // Transmit side
    input wire ngh_pkg::ngh_frame_s tx_frame,
    input wire logic tx_valid,
    input wire logic tx_ready,
    // Events
    input wire logic life_error,
    input wire logic hb_error,
    input wire logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // State code expected for the present state
    wire logic [6:0] exp_code = (nmt_state == ngh_pkg::NGH_NMT_STOP) ? 7'h04 :
        (nmt_state == ngh_pkg::NGH_NMT_OPER) ? 7'h05 :
        (nmt_state == ngh_pkg::NGH_NMT_PREOP) ? 7'h7F : 7'h00;
    // Frame offered but held off
    sequence s_wait;
        tx_valid && !tx_ready;
    endsequence
    // Frame taken by the controller
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_TX_HOLD: assert property (s_wait |=> tx_valid && $stable(tx_frame))
        else $error("frame changed before acceptance");
    AST_TX_COB: assert property (tx_valid |-> tx_frame.cob_id == 11'h700 + {4'h0, node_id})
        else $error("frame identifier wrong");
    AST_TX_DLC: assert property (tx_valid |-> tx_frame.dlc == 4'h1)
        else $error("frame length wrong");
    AST_STATE_CODE: assert property (tx_valid && $stable(nmt_state) |->
        tx_frame.data0[6:0] == exp_code)
        else $error("state code wrong");
    AST_NO_BOOT: assert property ((nmt_state == ngh_pkg::NGH_NMT_BOOT) [*3] |->
        !$rose(tx_valid))
        else $error("frame offered in boot state");
    AST_TX_DROP: assert property (s_take |=> !tx_valid)
        else $error("valid held after acceptance");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");
    AST_LIFE_PULSE: assert property (life_error |=> !life_error)
        else $error("lifetime event longer than a cycle");
    AST_HB_PULSE: assert property (hb_error |=> !hb_error)
        else $error("heartbeat event longer than a cycle");
endmodule

bind ngh_supervisor ngh_checker #(.TICK_CYC(TICK_CYC), .CONS_N(CONS_N)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_id(node_id),
    .nmt_state(nmt_state), .rx_guard_rtr(rx_guard_rtr), .rx_hb_valid(rx_hb_valid),
    .rx_hb_node(rx_hb_node), .tx_frame(tx_frame), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .life_error(life_error), .hb_error(hb_error), .irq(irq)
);

// *** testbench/ngh_peer_model.sv ***
// Behavioural guarding master and peer heartbeat producers
`timescale 1ns/1ps
module ngh_peer_model (
    // Clock
    input wire logic core_clk,
    // Pacing of acceptance
    input wire logic slow,
    // Frames towards the design
    output logic rx_guard_rtr = 1'b0,
    output logic rx_hb_valid = 1'b0,
    output logic [7:0] rx_hb_node = 8'h5A,
    // Transmit handshake
    input wire logic tx_valid,
    output logic tx_ready = 1'b0
);
    logic [1:0] pace = 2'h0; // Slow mode divider
    // replies collected, promptly or after a wait
    always @(posedge core_clk) begin
        pace <= pace + 2'(tx_valid);
        tx_ready <= !slow || (pace == 2'h3);
    end
    task automatic poll();
        @(posedge core_clk);
        rx_guard_rtr <= 1'b1;
        @(posedge core_clk);
        rx_guard_rtr <= 1'b0;
    endtask
    // one heartbeat, node lines scrambled afterwards
    task automatic send_hb(input logic [7:0] node);
        @(posedge core_clk);
        rx_hb_valid <= 1'b1;
        rx_hb_node <= node;
        @(posedge core_clk);
        rx_hb_valid <= 1'b0;
        rx_hb_node <= ~node;
    endtask
endmodule

// *** testbench/ngh_supervisor_bench.sv ***
// Self-checking bench for the guarding and heartbeat supervisor
`timescale 1ns/1ps
module ngh_supervisor_bench;
    // ----------------------------------------
    // Signals and scoreboard
    // ----------------------------------------
    localparam int TCK = 10; // Cycles per millisecond in simulation
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ngh_pkg::NGH_ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [6:0] node_id = 7'h01;
    ngh_pkg::ngh_nmt_e nmt_state = ngh_pkg::NGH_NMT_BOOT;
    logic rx_guard_rtr, rx_hb_valid, tx_valid, tx_ready, life_error, hb_error, irq;
    logic [7:0] rx_hb_node;
    ngh_pkg::ngh_frame_s tx_frame;
    logic slow = 1'b0; // Peer accepts slowly
    logic rd_seen = 1'b0; // Read data due this cycle
    logic [31:0] lfsr = 32'h0001_318F;
    int err_total = 0;
    int check_count = 0;
    logic [31:0] rd_q[$]; // Expected read data
    logic [22:0] fr_q[$]; // Expected frames
    logic [1:0] ev_q[$]; // Expected {hb, life} events
    ngh_pkg::ngh_nmt_e st_tab[3] = '{ngh_pkg::NGH_NMT_STOP, ngh_pkg::NGH_NMT_OPER,
        ngh_pkg::NGH_NMT_PREOP};
    logic [7:0] code_tab[3] = '{8'h04, 8'h85, 8'h7F}; // Toggle bit 0, 1, 0

    always #4 core_clk = ~core_clk;

    ngh_supervisor #(.TICK_CYC(TCK), .CONS_N(ngh_pkg::NGH_CONS_N)) DUT (
        .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .node_id(node_id),
        .nmt_state(nmt_state), .rx_guard_rtr(rx_guard_rtr), .rx_hb_valid(rx_hb_valid),
        .rx_hb_node(rx_hb_node), .tx_frame(tx_frame), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .life_error(life_error), .hb_error(hb_error), .irq(irq));
    ngh_peer_model PEER (.core_clk(core_clk), .slow(slow), .rx_guard_rtr(rx_guard_rtr),
        .rx_hb_valid(rx_hb_valid), .rx_hb_node(rx_hb_node), .tx_valid(tx_valid),
        .tx_ready(tx_ready));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Expected frame for a state byte
    function automatic logic [22:0] exp_fr(input logic [7:0] d);
        return {ngh_pkg::NGH_COB_BASE + {4'h0, node_id}, ngh_pkg::NGH_DLC, d};
    endfunction
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_frame(input logic [22:0] got, input logic [22:0] exp);
        cmp_word({9'h0, got}, {9'h0, exp});
    endtask
    task automatic reg_write(input logic [15:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [15:0] idx, input logic [31:0] exp);
        rd_q.push_back(exp);
        @(posedge core_clk);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    // Wait for all expectations to be met, bounded
    task automatic drain(input int lim);
        int n;
        n = 0;
        while ((fr_q.size() + ev_q.size() + rd_q.size()) != 0 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        cmp_word(32'(fr_q.size() + ev_q.size()), 32'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Output monitor
    // ----------------------------------------
    always @(posedge core_clk) begin
        rd_seen <= reg_rd;
        if (rd_seen) begin
            cmp_word(reg_rdata, rd_q.pop_front());
        end
        if (tx_valid && tx_ready) begin
            cmp_frame(tx_frame, fr_q.size() ? fr_q.pop_front() : '1);
        end
        if (life_error || hb_error) begin
            cmp_word({30'h0, hb_error, life_error},
                {30'h0, ev_q.size() ? ev_q.pop_front() : 2'b00});
        end
    end

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #400000;
        err_total++;
        $display("mismatch at %0t watchdog got %h expected %h", $time, 1'b1, 1'b0);
        complete_run();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        lfsr = lfsr_next(lfsr);
        node_id <= lfsr[6:0] | 7'h01;
        slow <= lfsr[9];
        // Test 1: reset values, consumer layout, unmapped place
        reg_read(ngh_pkg::NGH_IDX_GUARD, 32'h0);
        reg_read(ngh_pkg::NGH_IDX_LIFE, 32'h0);
        reg_read(ngh_pkg::NGH_IDX_PROD, 32'h0);
        reg_read(ngh_pkg::NGH_IDX_CONS, 32'h0);
        reg_write(ngh_pkg::NGH_IDX_CONS, 32'hAB12_0004);
        reg_read(ngh_pkg::NGH_IDX_CONS, 32'h0012_0004);
        reg_write(ngh_pkg::NGH_IDX_CTRL, 32'h1);
        reg_write(ngh_pkg::NGH_IDX_CONS, 32'h0013_0000);
        reg_read(16'h1F10, 32'h0);
        drain(10);
        $display("test 1 done");
        // Test 2: heartbeat producer, then disabled
        nmt_state <= ngh_pkg::NGH_NMT_OPER;
        repeat (3) fr_q.push_back(exp_fr(8'h05));
        reg_write(ngh_pkg::NGH_IDX_PROD, 32'h3);
        drain(150);
        reg_write(ngh_pkg::NGH_IDX_PROD, 32'h0);
        repeat (60) @(posedge core_clk);
        $display("test 2 done");
        // Test 3: guarding replies in each active state
        foreach (st_tab[i]) begin
            nmt_state <= st_tab[i];
            repeat (3) @(posedge core_clk);
            fr_q.push_back(exp_fr(code_tab[i]));
            PEER.poll();
            drain(40);
        end
        $display("test 3 done");
        // Test 4: life guarding, reload, interrupt, disable by zero factor
        reg_write(ngh_pkg::NGH_IDX_IRQ_MASK, 32'h3);
        reg_write(ngh_pkg::NGH_IDX_GUARD, 32'h2);
        reg_write(ngh_pkg::NGH_IDX_LIFE, 32'h3);
        fr_q.push_back(exp_fr(8'hFF));
        PEER.poll();
        repeat (40) @(posedge core_clk);
        fr_q.push_back(exp_fr(8'h7F));
        PEER.poll();
        repeat (50) @(posedge core_clk);
        ev_q.push_back(2'b01);
        drain(40);
        repeat (2) @(posedge core_clk);
        cmp_word({31'h0, irq}, 32'h1);
        reg_read(ngh_pkg::NGH_IDX_IRQ_STAT, 32'h1);
        reg_write(ngh_pkg::NGH_IDX_IRQ_STAT, 32'h1);
        repeat (3) @(posedge core_clk);
        cmp_word({31'h0, irq}, 32'h0);
        reg_write(ngh_pkg::NGH_IDX_LIFE, 32'h0);
        fr_q.push_back(exp_fr(8'hFF));
        PEER.poll();
        repeat (100) @(posedge core_clk);
        drain(5);
        $display("test 4 done");
        // Test 5: consumers armed by heartbeat, reload, timeout, zero entry
        lfsr = lfsr_next(lfsr);
        PEER.send_hb(lfsr[7:0] | 8'h40);
        PEER.send_hb(8'h13);
        PEER.send_hb(8'h12);
        repeat (20) @(posedge core_clk);
        PEER.send_hb(8'h12);
        repeat (30) @(posedge core_clk);
        ev_q.push_back(2'b10);
        drain(30);
        reg_read(ngh_pkg::NGH_IDX_IRQ_STAT, 32'h2);
        cmp_word({31'h0, irq}, 32'h1);
        drain(5);
        $display("test 5 done");
        complete_run();
    end
endmodule
